// ---- logic/kms_matrix_scanner.sv ----
// Key matrix scanner: drive line control, sense status, runtime and wake interrupts
//
// Function
// R1 - Predrive on: disable scan, set predrive, make drive buffers push-pull, re-enable.
// R2 - Predrive off: disable scan, make buffers open-drain, clear predrive, re-enable.
// R3 - Falling sense edges are flagged for interrupts even with bus clock stopped.
// R4 - Runtime interrupt output is an active-high level.
// R5 - Each sense input has a status bit set on high-to-low change.
// R6 - Input interrupts only while both its status and enable bits are set.
// R7 - Writing one clears a status bit; writing zero leaves it.
// R8 - Runtime interrupt is the OR of all per-input contributions.
// R9 - Once asserted, re-asserts only after all inputs high or selection changes.
// R10 - Enabled fall during stopped clock raises wake interrupt and clock-required bit.
// R11 - Wake interrupt stays asserted until the bus clock runs again.
// R12 - Sleep falls set status; enabled ones raise runtime interrupt on resume.
// R13 - Software should prefer the block wake interrupt over shared pin wake.
// R14 - Registers sit at fixed offsets from base address 4000_9C00h.
// R15 - Polarity bit 7 sets selected line level, 0 low, 1 high, resets 0.
// R16 - Scan disable bit 6 turns off scanning and all drive buffers, resets 1.
// R17 - All-lines bit 5 drives every drive line high; else select field rules.
// R18 - Five-bit select field picks one drive line, codes 0 to 0Ah.
// R19 - Sense input register returns present sense levels; writes ignored.
`timescale 1ns/1ps
module kms_matrix_scanner (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // Register access
  input  wire logic [31:0]                   reg_addr,
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  input  wire logic [kms_pkg::DATA_W-1:0]    reg_wdata,
  output logic      [kms_pkg::DATA_W-1:0]    reg_rdata,
  output logic                               reg_rdata_valid,
  // Key matrix
  input  wire logic [kms_pkg::NUM_SENSE-1:0] row_sense_input,
  output logic      [kms_pkg::NUM_DRIVE-1:0] column_drive_line,
  output logic      [kms_pkg::NUM_DRIVE-1:0] column_drive_oe,
  // Power state
  input  wire logic                          bus_clk_stopped,
  // Interrupts
  output logic                               matrix_runtime_irq,
  output logic                               matrix_wake_irq,
  output logic                               clock_required_status
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic kms_hit(input logic [31:0] addr, input logic [31:0] off);
    logic [31:0] target;
    target  = kms_pkg::BASE_ADDR + off; // Wraps, no carry kept
    kms_hit = (addr == target); // see R14
  endfunction

  function automatic logic [kms_pkg::NUM_SENSE-1:0] kms_sense_field(input logic [kms_pkg::DATA_W-1:0] word);
    kms_sense_field = word[kms_pkg::NUM_SENSE-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Sense conditioning
  // ----------------------------------------------------------------
  kms_sense_if sense ();

  kms_sense_front u_front (
    .core_clk        (core_clk),
    .rst             (rst),
    .row_sense_input (row_sense_input),
    .sense           (sense.src)
  );

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic wr_select;
  logic wr_status;
  logic wr_enable;
  logic wr_ext;

  assign wr_select = reg_wr_en & kms_hit(reg_addr, kms_pkg::OFF_SCAN_LINE_SELECT);
  assign wr_status = reg_wr_en & kms_hit(reg_addr, kms_pkg::OFF_SENSE_EDGE_STATUS);
  assign wr_enable = reg_wr_en & kms_hit(reg_addr, kms_pkg::OFF_SENSE_IRQ_ENABLE);
  assign wr_ext    = reg_wr_en & kms_hit(reg_addr, kms_pkg::OFF_SCAN_EXT_CONTROL);
  // Levels word has no write strobe; see R19

  // ----------------------------------------------------------------
  // Drive line select register
  // ----------------------------------------------------------------
  logic                      drive_polarity;
  logic                      scan_disable;
  logic                      drive_all_lines;
  logic [kms_pkg::IDX_W-1:0] drive_line_index;
  logic [kms_pkg::IDX_W-1:0] wr_index;
  logic                      select_changed;

  assign wr_index = reg_wdata[kms_pkg::IDX_LSB +: kms_pkg::IDX_W];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_polarity   <= kms_pkg::POL_RESET; // see R15
      scan_disable     <= kms_pkg::DIS_RESET; // see R16
      drive_all_lines  <= kms_pkg::ALL_RESET;
      drive_line_index <= kms_pkg::IDX_RESET;
    end else if (wr_select) begin
      drive_polarity   <= reg_wdata[kms_pkg::POL_BIT];
      scan_disable     <= reg_wdata[kms_pkg::DIS_BIT];
      drive_all_lines  <= reg_wdata[kms_pkg::ALL_BIT];
      drive_line_index <= wr_index;
    end
  end

  // A new line index re-arms the runtime interrupt
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      select_changed <= 1'b0;
    end else begin
      select_changed <= wr_select & (wr_index != drive_line_index); // see R9
    end
  end

  // ----------------------------------------------------------------
  // Extended control register
  // ----------------------------------------------------------------
  logic predrive_on;

  // Buffer type lives in the pad control; software orders the steps
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      predrive_on <= kms_pkg::PREDRIVE_RESET;
    end else if (wr_ext) begin
      predrive_on <= reg_wdata[kms_pkg::PREDRIVE_BIT]; // see R1 see R2
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  logic [kms_pkg::NUM_SENSE-1:0] sense_irq_enable;

  // Also gates the wake path while asleep
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sense_irq_enable <= kms_pkg::SENSE_ZERO;
    end else if (wr_enable) begin
      sense_irq_enable <= kms_sense_field(reg_wdata);
    end
  end

  // ----------------------------------------------------------------
  // Edge status register
  // ----------------------------------------------------------------
  logic [kms_pkg::NUM_SENSE-1:0] sense_edge_status;
  logic [kms_pkg::NUM_SENSE-1:0] clear_mask;
  logic [kms_pkg::NUM_SENSE-1:0] next_sense_edge_status;

  assign clear_mask = wr_status ? kms_sense_field(reg_wdata) : kms_pkg::SENSE_ZERO;

  // Set wins over a clear in the same cycle
  // Falls seen in sleep land here too
  always_comb begin
    next_sense_edge_status = (sense_edge_status & ~clear_mask) | sense.fall; // see R7 see R5 see R12
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sense_edge_status <= kms_pkg::SENSE_ZERO;
    end else begin
      sense_edge_status <= next_sense_edge_status;
    end
  end

  // ----------------------------------------------------------------
  // Runtime interrupt arming
  // ----------------------------------------------------------------
  logic [kms_pkg::NUM_SENSE-1:0] contrib;
  logic                          pending;
  kms_pkg::kms_irq_state_t       irq_state;
  kms_pkg::kms_irq_state_t       next_irq_state;
  logic                          rearm;

  assign contrib = next_sense_edge_status & sense_irq_enable; // see R6
  assign pending = |contrib;                                  // see R8
  // Every row released, or a new line chosen
  assign rearm   = sense.all_high | select_changed;           // see R9

  always_comb begin
    next_irq_state = irq_state;
    unique case (irq_state)
      kms_pkg::IRQ_ARMED: begin
        // Held off while the bus clock is stopped, raised on resume
        if (pending && !bus_clk_stopped) begin
          next_irq_state = kms_pkg::IRQ_ACTIVE; // see R12
        end
      end
      kms_pkg::IRQ_ACTIVE: begin
        if (!pending) begin
          if (rearm) begin
            next_irq_state = kms_pkg::IRQ_ARMED;
          end else begin
            next_irq_state = kms_pkg::IRQ_HOLD; // see R9
          end
        end
      end
      kms_pkg::IRQ_HOLD: begin
        if (rearm) begin
          next_irq_state = kms_pkg::IRQ_ARMED; // see R9
        end
      end
      default: begin
        next_irq_state = kms_pkg::IRQ_ARMED;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_state <= kms_pkg::IRQ_ARMED;
    end else begin
      irq_state <= next_irq_state;
    end
  end

  // Registered so the aggregator sees a clean level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      matrix_runtime_irq <= 1'b0;
    end else begin
      matrix_runtime_irq <= (next_irq_state == kms_pkg::IRQ_ACTIVE); // see R4 see R8
    end
  end

  // ----------------------------------------------------------------
  // Wake interrupt
  // ----------------------------------------------------------------
  logic                          wake_event;
  logic [kms_pkg::NUM_SENSE-1:0] wake_hits;

  // Needs the core clock alive; only the bus clock is assumed stopped
  assign wake_hits  = sense.fall & sense_irq_enable;
  assign wake_event = bus_clk_stopped & (|wake_hits); // see R3 see R10

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      matrix_wake_irq <= 1'b0;
    end else if (wake_event) begin
      matrix_wake_irq <= 1'b1; // see R10
    end else if (!bus_clk_stopped) begin
      matrix_wake_irq <= 1'b0; // see R11
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clock_required_status <= 1'b0;
    end else if (wake_event) begin
      clock_required_status <= 1'b1; // see R10
    end else if (!bus_clk_stopped) begin
      clock_required_status <= 1'b0; // see R11
    end
  end

  // ----------------------------------------------------------------
  // Drive line outputs
  // ----------------------------------------------------------------
  logic [kms_pkg::NUM_DRIVE-1:0] next_drive_line;
  logic [kms_pkg::NUM_DRIVE-1:0] next_drive_oe;
  logic [kms_pkg::NUM_DRIVE-1:0] idle_line;
  logic [kms_pkg::NUM_DRIVE-1:0] idle_oe;

  // Predrive keeps idle lines actively at the released level
  assign idle_line = drive_polarity ? kms_pkg::DRIVE_ZERO : kms_pkg::DRIVE_ONES;
  assign idle_oe   = predrive_on ? kms_pkg::DRIVE_ONES : kms_pkg::DRIVE_ZERO; // see R1 see R2

  always_comb begin
    next_drive_line = idle_line;
    next_drive_oe   = idle_oe;
    if (scan_disable) begin
      next_drive_line = kms_pkg::DRIVE_ZERO;
      next_drive_oe   = kms_pkg::DRIVE_ZERO; // see R16
    end else if (drive_all_lines) begin
      next_drive_line = kms_pkg::DRIVE_ONES;
      next_drive_oe   = kms_pkg::DRIVE_ONES; // see R17
    end else begin
      // Codes above ten select no line
      for (int i = 0; i < kms_pkg::NUM_DRIVE; i++) begin
        if (drive_line_index == i[kms_pkg::IDX_W-1:0]) begin
          next_drive_line[i] = drive_polarity; // see R15 see R18
          next_drive_oe[i]   = 1'b1;
        end
      end
    end
  end

  // Registered so pads never see decode glitches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      column_drive_line <= kms_pkg::DRIVE_ZERO;
      column_drive_oe   <= kms_pkg::DRIVE_ZERO;
    end else begin
      column_drive_line <= next_drive_line;
      column_drive_oe   <= next_drive_oe;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [kms_pkg::DATA_W-1:0] read_word;

  always_comb begin
    read_word = kms_pkg::WORD_ZERO;
    if (kms_hit(reg_addr, kms_pkg::OFF_SCAN_LINE_SELECT)) begin
      read_word[kms_pkg::POL_BIT]                         = drive_polarity;
      read_word[kms_pkg::DIS_BIT]                         = scan_disable;
      read_word[kms_pkg::ALL_BIT]                         = drive_all_lines;
      read_word[kms_pkg::IDX_LSB +: kms_pkg::IDX_W]       = drive_line_index;
    end else if (kms_hit(reg_addr, kms_pkg::OFF_SENSE_INPUT_LEVELS)) begin
      read_word[kms_pkg::NUM_SENSE-1:0]                   = sense.level; // see R19
    end else if (kms_hit(reg_addr, kms_pkg::OFF_SENSE_EDGE_STATUS)) begin
      read_word[kms_pkg::NUM_SENSE-1:0]                   = sense_edge_status;
    end else if (kms_hit(reg_addr, kms_pkg::OFF_SENSE_IRQ_ENABLE)) begin
      read_word[kms_pkg::NUM_SENSE-1:0]                   = sense_irq_enable;
    end else if (kms_hit(reg_addr, kms_pkg::OFF_SCAN_EXT_CONTROL)) begin
      read_word[kms_pkg::PREDRIVE_BIT]                    = predrive_on;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd_en;
    end
  end

  // Data holds between reads so software may sample late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= kms_pkg::WORD_ZERO;
    end else if (reg_rd_en) begin
      reg_rdata <= read_word;
    end
  end

endmodule // kms_matrix_scanner

// ---- logic/kms_pkg.sv ----
// Package with register map, field layout and state codes of the key matrix scanner
package kms_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SENSE   = 8;
  localparam int unsigned NUM_DRIVE   = 11;
  localparam int unsigned IDX_W       = 5;
  localparam int unsigned DATA_W      = 32;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] BASE_ADDR              = 32'h4000_9C00;
  localparam logic [31:0] OFF_RESERVED_SLOT      = 32'h0000_0000;
  localparam logic [31:0] OFF_SCAN_LINE_SELECT   = 32'h0000_0004;
  localparam logic [31:0] OFF_SENSE_INPUT_LEVELS = 32'h0000_0008;
  localparam logic [31:0] OFF_SENSE_EDGE_STATUS  = 32'h0000_000C;
  localparam logic [31:0] OFF_SENSE_IRQ_ENABLE   = 32'h0000_0010;
  localparam logic [31:0] OFF_SCAN_EXT_CONTROL   = 32'h0000_0014;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned POL_BIT      = 7;
  localparam int unsigned DIS_BIT      = 6;
  localparam int unsigned ALL_BIT      = 5;
  localparam int unsigned IDX_LSB      = 0;
  localparam int unsigned PREDRIVE_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic                 POL_RESET      = 1'h0;
  localparam logic                 DIS_RESET      = 1'h1;
  localparam logic                 ALL_RESET      = 1'h0;
  localparam logic [IDX_W-1:0]     IDX_RESET      = 5'h00;
  localparam logic                 PREDRIVE_RESET = 1'h0;
  localparam logic [NUM_SENSE-1:0] SENSE_ZERO     = 8'h00;
  localparam logic [NUM_SENSE-1:0] SENSE_ONES     = 8'hFF;
  localparam logic [NUM_DRIVE-1:0] DRIVE_ZERO     = 11'h000;
  localparam logic [NUM_DRIVE-1:0] DRIVE_ONES     = 11'h7FF;
  localparam logic [DATA_W-1:0]    WORD_ZERO      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Runtime interrupt arming states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IRQ_ARMED  = 3'h1,
    IRQ_ACTIVE = 3'h2,
    IRQ_HOLD   = 3'h4
  } kms_irq_state_t;

endpackage

// ---- logic/kms_sense_front.sv ----
// Sense input synchroniser and falling edge detector
`timescale 1ns/1ps
module kms_sense_front (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Matrix pins
  input  wire logic [kms_pkg::NUM_SENSE-1:0] row_sense_input,
  // Conditioned outputs
  kms_sense_if.src                         sense
);

  // ----------------------------------------------------------------
  // Two-flop synchroniser, then one history stage
  // ----------------------------------------------------------------
  logic [kms_pkg::NUM_SENSE-1:0] meta;
  logic [kms_pkg::NUM_SENSE-1:0] level_q;
  logic [kms_pkg::NUM_SENSE-1:0] prev_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta    <= kms_pkg::SENSE_ONES;
      level_q <= kms_pkg::SENSE_ONES;
      prev_q  <= kms_pkg::SENSE_ONES;
    end else begin
      meta    <= row_sense_input;
      level_q <= meta;
      prev_q  <= level_q;
    end
  end

  // Reset to ones so an input idle high at release gives no false edge
  assign sense.level    = level_q;
  assign sense.fall     = prev_q & ~level_q; // see R5
  assign sense.all_high = &level_q;

endmodule // kms_sense_front

// ---- logic/kms_sense_if.sv ----
// Interface carrying conditioned sense levels and fall pulses
`timescale 1ns/1ps
interface kms_sense_if;
  logic [7:0] level;
  logic [7:0] fall;
  logic       all_high;

  modport src (output level, output fall, output all_high);
  modport dst (input  level, input  fall, input  all_high);
endinterface

// ---- verif/kms_key_matrix.sv ----
// Behavioural key switch matrix with pulled-up sense rows
`timescale 1ns/1ps
module kms_key_matrix (
  // Column side
  input  wire logic [10:0]      column_drive_line,
  input  wire logic [10:0]      column_drive_oe,
  // Pressed keys, one column mask per row
  input  wire logic [7:0][10:0] key_down,
  // Row side
  output logic      [7:0]       row_sense_input
);
  // Pull-up wins unless a pressed key meets a column driven low;
  // columns driven high or released never pull a row down
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      row_sense_input[r] = ~|(key_down[r] & column_drive_oe & ~column_drive_line);
    end
  end
endmodule // kms_key_matrix

// ---- verif/kms_props.sv ----
// Port-level checker of the key matrix scanner
`timescale 1ns/1ps
module kms_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register access
  input wire logic [31:0] reg_addr,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rdata_valid,
  // Key matrix
  input wire logic [7:0]  row_sense_input,
  input wire logic [10:0] column_drive_line,
  input wire logic [10:0] column_drive_oe,
  // Power and interrupts
  input wire logic        bus_clk_stopped,
  input wire logic        matrix_runtime_irq,
  input wire logic        matrix_wake_irq,
  input wire logic        clock_required_status
);
  localparam logic [31:0] B = kms_pkg::BASE_ADDR;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence sel_wr;
    reg_wr_en && reg_addr == B + kms_pkg::OFF_SCAN_LINE_SELECT;
  endsequence
  // Synchroniser needs the pin settled before a read is exact
  sequence row_still;
    $stable(row_sense_input) [*4];
  endsequence
  sequence en_off;
    reg_wr_en && reg_addr == B + kms_pkg::OFF_SENSE_IRQ_ENABLE && reg_wdata[7:0] == 8'h00;
  endsequence
  AST_RD_PULSE: assert property (reg_rd_en |=> reg_rdata_valid)
    else $error("read strobe without valid pulse");
  AST_RSVD_ZERO: assert property (reg_rd_en && reg_addr == B |=> reg_rdata == 32'h0000_0000)
    else $error("reserved slot read not zero");
  AST_LEVELS: assert property (row_still ##0 (reg_rd_en && reg_addr == B + kms_pkg::OFF_SENSE_INPUT_LEVELS)
    |=> reg_rdata == {24'h00_0000, $past(row_sense_input)}) else $error("level read differs from pins");
  AST_DIS_OFF: assert property (sel_wr ##0 reg_wdata[6] |-> ##2 column_drive_oe == 11'h000)
    else $error("drive enabled while scan disabled");
  AST_SEL_LEVEL: assert property (sel_wr ##0 (reg_wdata[6:5] == 2'h0 && reg_wdata[4:0] <= 5'h0A) |-> ##2
    column_drive_oe[$past(reg_wdata[4:0], 2)] && column_drive_line[$past(reg_wdata[4:0], 2)] == $past(reg_wdata[7], 2))
    else $error("selected line wrong");
  AST_ALL_HIGH: assert property (sel_wr ##0 reg_wdata[6:5] == 2'h1 |-> ##2
    column_drive_oe == 11'h7FF && column_drive_line == 11'h7FF) else $error("all lines not high");
  AST_WAKE_CLEAR: assert property (!bus_clk_stopped |=> !matrix_wake_irq)
    else $error("wake irq while bus clock runs");
  AST_WAKE_CAUSE: assert property ($rose(matrix_wake_irq) |-> $past(bus_clk_stopped))
    else $error("wake irq outside sleep");
  AST_WAKE_STATUS: assert property (matrix_wake_irq == clock_required_status)
    else $error("clock required differs from wake irq");
  AST_RT_AWAKE: assert property ($rose(matrix_runtime_irq) |-> !$past(bus_clk_stopped))
    else $error("runtime irq rose in sleep");
  AST_EN_OFF: assert property (en_off ##1 !reg_wr_en |-> ##1 !matrix_runtime_irq)
    else $error("runtime irq with no enable");
endmodule // kms_props

bind kms_matrix_scanner kms_props u_props (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid), .row_sense_input(row_sense_input), .column_drive_line(column_drive_line),
  .column_drive_oe(column_drive_oe), .bus_clk_stopped(bus_clk_stopped), .matrix_runtime_irq(matrix_runtime_irq),
  .matrix_wake_irq(matrix_wake_irq), .clock_required_status(clock_required_status));

// ---- verif/testbench.sv ----
// Directed self-checking bench of the key matrix scanner
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic             core_clk, rst, reg_wr_en, reg_rd_en, reg_rdata_valid, bus_clk_stopped;
  logic             matrix_runtime_irq, matrix_wake_irq, clock_required_status;
  logic [31:0]      reg_addr, reg_wdata, reg_rdata;
  logic [7:0]       row_sense_input;
  logic [10:0]      column_drive_line, column_drive_oe;
  logic [7:0][10:0] key_down;
  int               fail_count, cmp_count;
  kms_matrix_scanner DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .row_sense_input(row_sense_input), .column_drive_line(column_drive_line), .column_drive_oe(column_drive_oe),
    .bus_clk_stopped(bus_clk_stopped), .matrix_runtime_irq(matrix_runtime_irq), .matrix_wake_irq(matrix_wake_irq),
    .clock_required_status(clock_required_status));
  kms_key_matrix keys (.column_drive_line(column_drive_line), .column_drive_oe(column_drive_oe),
    .key_down(key_down), .row_sense_input(row_sense_input));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic flag(input string what, input logic seen, input logic exp);
    chk(what, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic wr(input logic [31:0] off, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'h1;
    reg_addr  <= kms_pkg::BASE_ADDR + off;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [31:0] off, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd_en <= 1'h1;
    reg_addr  <= kms_pkg::BASE_ADDR + off;
    @(posedge core_clk);
    reg_rd_en <= 1'h0;
    #1;
    flag("rdata_valid", reg_rdata_valid, 1'h1);
    chk("rdata", reg_rdata, exp);
  endtask
  task automatic drv(input logic [10:0] oe, input logic [10:0] line);
    repeat (2) @(posedge core_clk);
    #1;
    chk("drive_oe", {21'h0, column_drive_oe}, {21'h0, oe});
    chk("drive_line", {21'h0, column_drive_line}, {21'h0, line});
  endtask
  // Edge path latency is fixed: two sync flops, history, status
  task automatic key(input int r, input int c, input logic v);
    @(posedge core_clk);
    key_down[r][c] <= v;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_rt(input logic v);
    int n;
    #1;
    for (n = 0; n < 20 && matrix_runtime_irq !== v; n++) begin
      @(posedge core_clk);
      #1;
    end
    flag("runtime_irq", matrix_runtime_irq, v);
    if (matrix_runtime_irq !== v) end_sim();
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #300000;
    $display("Error run_time expected finish seen hang");
    fail_count++;
    end_sim();
  end
  initial begin
    logic [10:0] s;
    rst             = 1'h1;
    reg_addr        = 32'h0000_0000;
    reg_wr_en       = 1'h0;
    reg_rd_en       = 1'h0;
    reg_wdata       = 32'h0000_0000;
    bus_clk_stopped = 1'h0;
    key_down        = 88'h0;
    fail_count      = 0;
    cmp_count       = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    rd(32'h04, 32'h0000_0040);
    rd(32'h14, 32'h0000_0000);
    rd(32'h0C, 32'h0000_0000);
    rd(32'h10, 32'h0000_0000);
    wr(32'h00, 32'hFFFF_FFFF);
    rd(32'h00, 32'h0000_0000);
    rd(32'h18, 32'h0000_0000);
    wr(32'h08, 32'h0000_0000);
    rd(32'h08, 32'h0000_00FF);
    for (int i = 0; i < 11; i++) begin
      s = 11'h001 << i;
      wr(32'h04, {24'h00_0000, i[0], 2'h0, i[4:0]});
      drv(s, i[0] ? s : ~s);
    end
    wr(32'h04, 32'h0000_000B);
    drv(11'h000, 11'h7FF);
    wr(32'h04, 32'h0000_0020);
    drv(11'h7FF, 11'h7FF);
    wr(32'h04, 32'h0000_0065);
    drv(11'h000, 11'h000);
    wr(32'h04, 32'h0000_0040);
    wr(32'h14, 32'h0000_0001);
    wr(32'h04, 32'h0000_0003);
    drv(11'h7FF, 11'h7F7);
    wr(32'h04, 32'h0000_0040);
    wr(32'h14, 32'h0000_0000);
    wr(32'h04, 32'h0000_0003);
    drv(11'h008, 11'h7F7);
    wr(32'h10, 32'h0000_0003);
    key(0, 3, 1'h1);
    wait_rt(1'h1);
    rd(32'h0C, 32'h0000_0001);
    wr(32'h0C, 32'h0000_0000);
    rd(32'h0C, 32'h0000_0001);
    wr(32'h0C, 32'h0000_0001);
    wait_rt(1'h0);
    key(1, 3, 1'h1);
    flag("runtime_irq", matrix_runtime_irq, 1'h0);
    rd(32'h0C, 32'h0000_0002);
    @(posedge core_clk);
    key_down <= 88'h0;
    wait_rt(1'h1);
    wr(32'h0C, 32'h0000_00FF);
    wait_rt(1'h0);
    wr(32'h10, 32'h0000_0001);
    key(2, 3, 1'h1);
    flag("runtime_irq", matrix_runtime_irq, 1'h0);
    rd(32'h0C, 32'h0000_0004);
    wr(32'h10, 32'h0000_0005);
    wait_rt(1'h1);
    wr(32'h10, 32'h0000_0000);
    wait_rt(1'h0);
    key(2, 3, 1'h0);
    wr(32'h0C, 32'h0000_00FF);
    wr(32'h10, 32'h0000_0010);
    @(posedge core_clk);
    bus_clk_stopped <= 1'h1;
    key(4, 3, 1'h1);
    flag("wake_irq", matrix_wake_irq, 1'h1);
    flag("clock_required", clock_required_status, 1'h1);
    repeat (8) @(posedge core_clk);
    #1;
    flag("wake_irq", matrix_wake_irq, 1'h1);
    flag("runtime_irq", matrix_runtime_irq, 1'h0);
    @(posedge core_clk);
    bus_clk_stopped <= 1'h0;
    wait_rt(1'h1);
    flag("wake_irq", matrix_wake_irq, 1'h0);
    rd(32'h0C, 32'h0000_0010);
    end_sim();
  end
endmodule // testbench
